/* File: verilog/sps_pkg.sv */
// Constants shared by the system power sequencer design.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package sps_pkg;
	// Clock and delays
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned LOCKOUT_MS = 5000;
	localparam int unsigned POWER_GOOD_MS = 5000;
	localparam int unsigned LOCKOUT_CYC = LOCKOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned POWER_GOOD_CYC = POWER_GOOD_MS * (CLK_HZ / 1000);
	localparam int unsigned POR_PULSE_US = 10;
	localparam int unsigned POR_CYC = POR_PULSE_US * (CLK_HZ / 1_000_000);
	// Stepping sequencer positions
	localparam int POS_W = 5;
	localparam logic [4:0] POS_START = 5'h1A;
	localparam logic [4:0] POS_FIRST = 5'h01;
	localparam logic [4:0] POS_CHAN1 = 5'h02;
	localparam logic [4:0] POS_CHAN3 = 5'h04;
	localparam logic [4:0] POS_SKIP_LO = 5'h05;
	localparam logic [4:0] POS_SKIP_HI = 5'h0A;
	localparam logic [4:0] POS_STOR1 = 5'h0B;
	localparam logic [4:0] POS_BULK1 = 5'h0F;
	localparam logic [4:0] POS_BULK4 = 5'h12;
	localparam logic [4:0] POS_TAIL_LO = 5'h13;
	localparam logic [4:0] POS_TAIL_HI = 5'h18;
	localparam logic [4:0] POS_ORIG_END = 5'h19;
	localparam logic [4:0] CHAN_BASE = 5'h02;
	localparam logic [4:0] STOR_BASE = 5'h08;
	// Attached units: 3 channels, 4 storage, 4 bulk storage
	localparam int NUM_UNITS = 11;
	localparam int NUM_CHAN = 3;
	localparam int NUM_FLAGS = 7;
	localparam logic [3:0] NO_UNIT = 4'hF;
	// Register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_UNITS = 8'h0C;
	localparam int CTRL_CONV_BIT = 0;
	localparam int CTRL_48V_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int CMD_SYS_ON = 0;
	localparam int CMD_SYS_OFF = 1;
	localparam int CMD_CPU_ON = 2;
	localparam int ST_POS_LSB = 0;
	localparam int ST_SEC_BIT = 8;
	localparam int ST_STOR_BIT = 9;
	localparam int ST_SYS_BIT = 10;
	localparam int ST_PROC_BIT = 11;
	localparam int ST_LOCK_BIT = 12;
	localparam int ST_PG_BIT = 13;
	localparam int ST_UV_BIT = 14;
	localparam int ST_PRIM_BIT = 15;
	localparam int UN_FLAG_LSB = 0;
	localparam int UN_REQ_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: verilog/sps_sequencer.sv */
// System power sequencer: stepping sequencer, holds, timers, reset pulses
// and an AXI4-Lite slave. Inputs are synchronous to clk_sys_in.
//
// What this block does
// - No undervoltage confirmation at power-good transfer drops secondary
// - Both confirmations clear the restart lockout timer
// - Optional 48 V output only with hold and confirmations
// - Power-good transfer emits one power-on reset pulse
// - Confirmations advance sequencer from position 1 to 2
// - Position 2 requests channel 1, completion advances, flag
// - Positions 3, 4 request channels 2, 3 with flags
// - Positions 5 to 10 step automatically to 11
// - Positions 11 to 14 request storage units, flags
// - Positions 15 to 18 request bulk units, no flags
// - Converted variant steps on to start position 26
// - Original variant stops at 25 with second pulse
// - Processor-only on needs lockout timer permission
// - Emergency drops everything; off or fault drops secondary
// - System off releases storage, returns to 26
// - Holds drop only after storage is down
// - Channel hold released with the system hold
// - Completed off sequence re-arms the lockout timer
// - Processor off drops only processor secondary power
// - After processor off, on waits for ready and lockout
// - Lockout timer transfers five seconds after its pick
// - Power-good timer runs five seconds from secondary hold
`timescale 1ns/1ns
`default_nettype none
module sps_sequencer
	import sps_pkg::*;
#(
	parameter int unsigned LOCK_CYC = LOCKOUT_CYC,
	parameter int unsigned PG_CYC = POWER_GOOD_CYC
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Operator controls
	input wire logic power_on_btn_in,
	input wire logic power_off_btn_in,
	input wire logic cpu_on_btn_in,
	input wire logic cpu_ready_in,
	input wire logic emergency_off_in,
	input wire logic auto_fault_in,
	// Regulator sense
	input wire logic undervoltage_ok_a_in,
	input wire logic undervoltage_ok_b_in,
	// Attached units
	input wire logic [NUM_UNITS-1:0] pwr_complete_in,
	input wire logic storage_down_in,
	output logic [NUM_UNITS-1:0] pwr_request_out,
	output logic storage_hold_out,
	output logic channel_hold_out,
	// Power outputs
	output logic primary_power_out,
	output logic processor_power_contactor_out,
	output logic aux_supply_relay_out,
	output logic por_pulse_out,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);
	localparam int LW = $clog2(LOCK_CYC + 1);
	localparam int PW = $clog2(PG_CYC + 1);
	localparam int RW = $clog2(POR_CYC + 1);
	localparam logic [LW-1:0] LOCK_END = LW'(LOCK_CYC);
	localparam logic [PW-1:0] PG_END = PW'(PG_CYC);
	localparam logic [PW-1:0] PG_FIRE = PW'(PG_CYC - 1);
	localparam logic [RW-1:0] POR_LEN = RW'(POR_CYC);

	// Unit index served at a position, NO_UNIT where none
	function automatic logic [3:0] unit_at(input logic [4:0] p);
		logic [3:0] u;
		u = NO_UNIT;
		if (p >= POS_CHAN1 && p <= POS_CHAN3) begin
			u = 4'(p - CHAN_BASE);
		end else if (p >= POS_STOR1 && p <= POS_BULK4) begin
			u = 4'(p - STOR_BASE);
		end
		return u;
	endfunction

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return a == ADDR_CTRL || a == ADDR_CMD || a == ADDR_STATUS || a == ADDR_UNITS;
	endfunction

	logic on_btn_q, off_btn_q, cpu_on_q, ready_q, emerg_q, fault_q, uv_a_q, uv_b_q;
	logic stor_down_q;
	logic [NUM_UNITS-1:0] complete_q;
	logic [1:0] ctrl_reg;
	logic [2:0] cmd_reg;
	logic [4:0] pos_reg;
	logic [LW-1:0] lock_cnt_reg;
	logic [PW-1:0] pg_cnt_reg;
	logic [RW-1:0] por_cnt_reg;
	logic secondary_hold_reg, system_hold_reg, storage_hold_reg, proc_only_hold_reg;
	logic [NUM_FLAGS-1:0] flags_reg;
	logic [NUM_UNITS-1:0] req_reg;
	logic chan_hold_reg, primary_reg, aux_reg, por_reg;
	logic uv_ok, lockout_ok, pg_done, pg_fire, on_req, off_req, cpu_req;
	logic start_sys, start_cpu, drop_all, unit_done, orig_fire, stepping;
	logic [3:0] unit;

	// Sampled operator, sense and handshake inputs
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			{on_btn_q, off_btn_q, cpu_on_q, ready_q, emerg_q, fault_q} <= '0;
			{uv_a_q, uv_b_q, stor_down_q} <= '0;
			complete_q <= '0;
		end else begin
			{on_btn_q, off_btn_q, cpu_on_q, ready_q} <= {power_on_btn_in, power_off_btn_in,
				cpu_on_btn_in, cpu_ready_in};
			{emerg_q, fault_q, uv_a_q, uv_b_q} <= {emergency_off_in, auto_fault_in,
				undervoltage_ok_a_in, undervoltage_ok_b_in};
			stor_down_q <= storage_down_in;
			complete_q <= pwr_complete_in;
		end
	end

	assign uv_ok = uv_a_q & uv_b_q;
	assign lockout_ok = lock_cnt_reg == LOCK_END;
	assign pg_done = pg_cnt_reg == PG_END;
	assign pg_fire = secondary_hold_reg && pg_cnt_reg == PG_FIRE;
	assign on_req = on_btn_q | cmd_reg[CMD_SYS_ON];
	assign off_req = off_btn_q | cmd_reg[CMD_SYS_OFF];
	assign cpu_req = cpu_on_q | cmd_reg[CMD_CPU_ON];
	assign start_sys = on_req && lockout_ok && !system_hold_reg && !emerg_q && ready_q
		&& !fault_q && !off_req && (pos_reg == POS_START || pos_reg == POS_ORIG_END);
	assign start_cpu = cpu_req && lockout_ok && !secondary_hold_reg && !emerg_q && ready_q
		&& !fault_q;
	assign drop_all = system_hold_reg && !storage_hold_reg && stor_down_q;
	assign unit = unit_at(pos_reg);
	assign unit_done = unit != NO_UNIT && req_reg[unit] && complete_q[unit];
	assign stepping = (pos_reg >= POS_SKIP_LO && pos_reg <= POS_SKIP_HI)
		|| (pos_reg >= POS_TAIL_LO && pos_reg <= POS_TAIL_HI);
	assign orig_fire = !emerg_q && !off_req && !ctrl_reg[CTRL_CONV_BIT]
		&& pos_reg == POS_TAIL_HI;

	// Restart lockout timer: picks with processor ready and no fault
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			lock_cnt_reg <= '0;
		end else if (uv_ok || !ready_q || fault_q || off_btn_q || emerg_q) begin
			lock_cnt_reg <= '0;
		end else if (!lockout_ok) begin
			lock_cnt_reg <= lock_cnt_reg + 1'b1;
		end
	end

	// Power-good timer, energised through the secondary hold
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || !secondary_hold_reg) begin
			pg_cnt_reg <= '0;
		end else if (!pg_done) begin
			pg_cnt_reg <= pg_cnt_reg + 1'b1;
		end
	end

	// Secondary hold and processor power contactor
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			secondary_hold_reg <= 1'b0;
		end else if (emerg_q || !ready_q || fault_q) begin
			secondary_hold_reg <= 1'b0;
		end else if (pg_done && !uv_ok) begin
			secondary_hold_reg <= 1'b0;
		end else if (drop_all) begin
			secondary_hold_reg <= 1'b0;
		end else if (start_sys || start_cpu) begin
			secondary_hold_reg <= 1'b1;
		end
	end

	// System, storage and processor-only holds
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || emerg_q) begin
			system_hold_reg <= 1'b0;
			storage_hold_reg <= 1'b0;
			proc_only_hold_reg <= 1'b0;
		end else if (start_sys) begin
			system_hold_reg <= 1'b1;
			storage_hold_reg <= 1'b1;
			proc_only_hold_reg <= 1'b1;
		end else if (off_req) begin
			storage_hold_reg <= 1'b0;
		end else if (drop_all) begin
			system_hold_reg <= 1'b0;
			proc_only_hold_reg <= 1'b0;
		end
	end

	// Stepping sequencer
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || emerg_q || off_req) begin
			pos_reg <= POS_START;
		end else if (start_sys) begin
			pos_reg <= POS_FIRST;
		end else if (pos_reg == POS_FIRST) begin
			if (uv_ok && secondary_hold_reg) begin
				pos_reg <= POS_CHAN1;
			end
		end else if (unit_done || stepping) begin
			pos_reg <= pos_reg + 5'h01;
		end else if (pos_reg == POS_ORIG_END && ctrl_reg[CTRL_CONV_BIT]) begin
			pos_reg <= POS_START;
		end
	end

	// Unit requests: one unit at a time, behind the relevant holds
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			req_reg <= '0;
		end else begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				req_reg[i] <= unit == 4'(i) && system_hold_reg && !emerg_q && !off_req
					&& !unit_done && (i < NUM_CHAN || storage_hold_reg);
			end
		end
	end

	// Per-unit on flags for channels and main storage only
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || emerg_q || drop_all) begin
			flags_reg <= '0;
		end else if (unit_done && unit < 4'(NUM_FLAGS)) begin
			flags_reg[unit[2:0]] <= 1'b1;
		end
	end

	// Power-on reset pulse: fixed length per trigger
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			por_cnt_reg <= '0;
			por_reg <= 1'b0;
		end else if ((pg_fire && uv_ok) || orig_fire) begin
			por_cnt_reg <= POR_LEN;
			por_reg <= 1'b1;
		end else begin
			if (por_cnt_reg != '0) begin
				por_cnt_reg <= por_cnt_reg - 1'b1;
			end
			por_reg <= por_cnt_reg > RW'(1);
		end
	end

	// Registered power outputs
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			primary_reg <= 1'b0;
			aux_reg <= 1'b0;
			chan_hold_reg <= 1'b0;
		end else begin
			primary_reg <= !emerg_q;
			aux_reg <= ctrl_reg[CTRL_48V_BIT] && secondary_hold_reg && uv_ok;
			chan_hold_reg <= system_hold_reg && !emerg_q;
		end
	end

	assign pwr_request_out = req_reg;
	assign storage_hold_out = storage_hold_reg;
	assign channel_hold_out = chan_hold_reg;
	assign primary_power_out = primary_reg;
	assign processor_power_contactor_out = secondary_hold_reg;
	assign aux_supply_relay_out = aux_reg;
	assign por_pulse_out = por_reg;

	// AXI4-Lite write channel
	logic awready_reg, wready_reg, bvalid_reg, aw_have, w_have;
	logic [1:0] bresp_reg;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0] wbyte_q;
	logic do_write;
	assign do_write = aw_have && w_have && !bvalid_reg;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			awaddr_q <= '0;
			wbyte_q <= '0;
			ctrl_reg <= CTRL_RESET;
			cmd_reg <= '0;
		end else begin
			cmd_reg <= '0;
			awready_reg <= !(aw_have || (s_axi_awvalid_in && awready_reg)) || do_write;
			wready_reg <= !(w_have || (s_axi_wvalid_in && wready_reg)) || do_write;
			if (s_axi_awvalid_in && awready_reg) begin
				aw_have <= 1'b1;
				awaddr_q <= s_axi_awaddr_in;
				awready_reg <= 1'b0;
			end
			if (s_axi_wvalid_in && wready_reg) begin
				w_have <= 1'b1;
				wbyte_q <= s_axi_wstrb_in[0] ? s_axi_wdata_in[7:0] : 8'h00;
				wready_reg <= 1'b0;
			end
			if (s_axi_bvalid_out && s_axi_bready_in) begin
				bvalid_reg <= 1'b0;
			end
			if (do_write) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= addr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
				if (awaddr_q == ADDR_CTRL) begin
					ctrl_reg <= wbyte_q[1:0];
				end
				if (awaddr_q == ADDR_CMD) begin
					cmd_reg <= wbyte_q[2:0];
				end
			end
		end
	end

	// AXI4-Lite read channel
	logic arready_reg, rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg, status_w, units_w;
	always_comb begin
		status_w = '0;
		status_w[ST_POS_LSB +: POS_W] = pos_reg;
		status_w[ST_SEC_BIT] = secondary_hold_reg;
		status_w[ST_STOR_BIT] = storage_hold_reg;
		status_w[ST_SYS_BIT] = system_hold_reg;
		status_w[ST_PROC_BIT] = proc_only_hold_reg;
		status_w[ST_LOCK_BIT] = lockout_ok;
		status_w[ST_PG_BIT] = pg_done;
		status_w[ST_UV_BIT] = uv_ok;
		status_w[ST_PRIM_BIT] = primary_reg;
		units_w = '0;
		units_w[UN_FLAG_LSB +: NUM_FLAGS] = flags_reg;
		units_w[UN_REQ_LSB +: NUM_UNITS] = req_reg;
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= '0;
		end else if (s_axi_arvalid_in && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rresp_reg <= addr_mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr_in)
				ADDR_CTRL: rdata_reg <= {30'h0, ctrl_reg};
				ADDR_STATUS: rdata_reg <= status_w;
				ADDR_UNITS: rdata_reg <= units_w;
				default: rdata_reg <= '0;
			endcase
		end else if (rvalid_reg && s_axi_rready_in) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end else if (!rvalid_reg) begin
			arready_reg <= 1'b1;
		end
	end

	assign s_axi_awready_out = awready_reg;
	assign s_axi_wready_out = wready_reg;
	assign s_axi_bvalid_out = bvalid_reg;
	assign s_axi_bresp_out = bresp_reg;
	assign s_axi_arready_out = arready_reg;
	assign s_axi_rvalid_out = rvalid_reg;
	assign s_axi_rresp_out = rresp_reg;
	assign s_axi_rdata_out = rdata_reg;

	// Checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);

	logic [RW:0] por_seen;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || !por_reg) begin
			por_seen <= '0;
		end else begin
			por_seen <= por_seen + 1'b1;
		end
	end

	a_uv_secondary_drop: assert property (secondary_hold_reg && pg_done && !uv_ok
		|=> !secondary_hold_reg) else $error("secondary hold kept without confirmation");
	a_lockout_clear: assert property (uv_ok |=> lock_cnt_reg == '0)
		else $error("lockout timer not dropped");
	a_aux_supply_gate: assert property (aux_supply_relay_out
		|-> $past(secondary_hold_reg && uv_ok && ctrl_reg[CTRL_48V_BIT]))
		else $error("48 V output without hold");
	a_pulse_length: assert property ($fell(por_reg) |-> por_seen == (RW+1)'(POR_CYC))
		else $error("reset pulse has wrong length");
	a_first_advance: assert property (pos_reg == POS_FIRST && uv_ok && secondary_hold_reg
		&& !emerg_q && !off_req && !start_sys |=> pos_reg == POS_CHAN1)
		else $error("position 1 did not advance");
	a_one_request: assert property ($onehot0(req_reg))
		else $error("more than one unit requested");
	a_chan1_flag: assert property (pos_reg == POS_CHAN1 && req_reg[0] && complete_q[0]
		&& !emerg_q && !off_req |=> pos_reg == 5'h03 && flags_reg[0])
		else $error("channel 1 completion lost");
	a_skip_step: assert property (pos_reg >= POS_SKIP_LO && pos_reg <= POS_SKIP_HI
		&& !emerg_q && !off_req |=> pos_reg == $past(pos_reg) + 5'h01)
		else $error("unused position not skipped");
	a_bulk_no_flag: assert property (pos_reg >= POS_BULK1 && unit_done && !emerg_q
		&& !drop_all |=> flags_reg == $past(flags_reg))
		else $error("bulk unit latched a flag");
	a_conv_finish: assert property (ctrl_reg[CTRL_CONV_BIT] && pos_reg == POS_ORIG_END
		&& !start_sys |=> pos_reg == POS_START) else $error("converted end missed");
	a_orig_pulse: assert property (orig_fire |=> pos_reg == POS_ORIG_END && por_reg)
		else $error("original end pulse missing");
	a_emerg_drop: assert property (emerg_q |=> !primary_power_out && !secondary_hold_reg
		&& !system_hold_reg) else $error("emergency off left power on");
	a_off_return: assert property (off_req && !emerg_q |=> pos_reg == POS_START
		&& !storage_hold_reg) else $error("system off not applied");
	a_hold_order: assert property ($fell(system_hold_reg) && !$past(emerg_q)
		|-> $past(stor_down_q) && !$past(storage_hold_reg))
		else $error("system hold dropped before storage");
	a_chan_hold: assert property (channel_hold_out |-> $past(system_hold_reg))
		else $error("channel hold without system hold");
	a_on_blocked: assert property (!lockout_ok && !secondary_hold_reg
		|=> !secondary_hold_reg) else $error("on request passed lockout");
	a_ready_off: assert property (!ready_q |=> !secondary_hold_reg
		&& system_hold_reg == $past(system_hold_reg || start_sys) || $past(emerg_q || drop_all))
		else $error("processor off misapplied");
endmodule // sps_sequencer
`default_nettype wire

/* File: test/sps_unit_model.sv */
// Model of the attached units' own power sequencers.
// Assumes the sequencer's request and storage hold levels on one clock.
`timescale 1ns/1ns
`default_nettype none
module sps_unit_model
	import sps_pkg::*;
#(
	parameter logic [10:0] ABSENT = 11'h0A0,
	parameter logic [10:0] LOCAL = 11'h400
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Sequencer side
	input wire logic [NUM_UNITS-1:0] pwr_request_in,
	input wire logic storage_hold_in,
	output logic [NUM_UNITS-1:0] pwr_complete_out,
	output logic storage_down_out
);
	logic [6:0] cnt_reg;
	logic done_reg;
	logic [3:0] down_reg;
	logic [10:0] strapped;
	// Units in local control are bypassed like absent ones
	assign strapped = ABSENT | LOCAL;
	// Remote units take long enough that the two reset pulses never merge
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || (pwr_request_in & ~strapped) == 11'h000) begin
			cnt_reg <= 7'h00;
			done_reg <= 1'b0;
		end else if (cnt_reg == 7'h50) begin
			done_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 7'h01;
		end
	end
	// Absent and local units are strapped to complete
	assign pwr_complete_out = strapped | (done_reg ? pwr_request_in : 11'h000);
	// Storage reports down some cycles after its hold drops
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || storage_hold_in) down_reg <= 4'h0;
		else if (down_reg != 4'hF) down_reg <= down_reg + 4'h1;
	end
	assign storage_down_out = (down_reg == 4'hF);
endmodule // sps_unit_model
`default_nettype wire

/* File: test/system_power_sequencer_tb_top.sv */
// Testbench for the system power sequencer with attached unit models.
// Assumes short timer parameters and an AXI4-Lite master in the bench.
`timescale 1ns/1ns
`default_nettype none
module system_power_sequencer_tb_top
	import sps_pkg::*;
;
	localparam int LK = 20;
	localparam int PG = 30;
	logic clk_sys_in = 1'b0, sys_rst_in = 1'b1;
	logic on_b = 0, off_b = 0, cpu_b = 0, rdy = 1, emergency_off = 0, flt = 0, uv = 0;
	logic [10:0] cmpl, req, req_q = '0;
	logic sdown, shold, chold, prim, ctr, aux, por;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rd;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int failures = 0, check_count = 0, multi = 0, por_n = 0, por_len = 0, plen = 0;
	int ord[$];
	always #10 clk_sys_in = ~clk_sys_in;
	sps_sequencer #(.LOCK_CYC(LK), .PG_CYC(PG)) DUT (.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in), .power_on_btn_in(on_b), .power_off_btn_in(off_b),
		.cpu_on_btn_in(cpu_b), .cpu_ready_in(rdy), .emergency_off_in(emergency_off),
		.auto_fault_in(flt), .undervoltage_ok_a_in(uv), .undervoltage_ok_b_in(uv),
		.pwr_complete_in(cmpl), .storage_down_in(sdown), .pwr_request_out(req),
		.storage_hold_out(shold), .channel_hold_out(chold), .primary_power_out(prim),
		.processor_power_contactor_out(ctr), .aux_supply_relay_out(aux),
		.por_pulse_out(por), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready));
	sps_unit_model UNITS (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.pwr_request_in(req), .storage_hold_in(shold), .pwr_complete_out(cmpl),
		.storage_down_out(sdown));
	// Records request order, overlap and reset pulse lengths
	always @(posedge clk_sys_in) begin
		req_q <= req;
		for (int i = 0; i < NUM_UNITS; i++) if (req[i] && !req_q[i]) ord.push_back(i);
		if ($countones(req) > 1) multi++;
		if (por) plen++;
		if (!por && plen != 0) begin
			por_n++;
			por_len = plen;
			plen = 0;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 100);
		bready <= 1'b0;
		chk(bvalid, 1'b1);
		chk(bresp, RESP_OKAY);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 100);
		d = rdata;
		rready <= 1'b0;
		chk(rvalid, 1'b1);
		chk(rresp, er);
	endtask
	task automatic wait_pos(input logic [4:0] p);
		rd = '0;
		for (int k = 0; k < 300 && rd[4:0] !== p; k++) axr(ADDR_STATUS, rd, RESP_OKAY);
		chk(rd[4:0], p);
	endtask
	task automatic wait_ctr(input logic v);
		for (int k = 0; k < 50 && ctr !== v; k++) @(posedge clk_sys_in);
	endtask
	task automatic wait_por;
		for (int k = 0; k < 1000 && (por || plen != 0); k++) @(posedge clk_sys_in);
	endtask
	task automatic t_regs;
		axr(ADDR_CTRL, rd, RESP_OKAY);
		chk(rd, 32'h0);
		axw(ADDR_CTRL, 32'h3);
		axr(ADDR_CTRL, rd, RESP_OKAY);
		chk(rd, 32'h3);
		axr(8'h10, rd, RESP_SLVERR);
		chk(rd, 32'h0);
	endtask
	task automatic t_on_conv;
		cyc(2 * LK);
		on_b <= 1'b1;
		cyc(1);
		on_b <= 1'b0;
		wait_ctr(1'b1);
		cyc(10);
		chk(req, 11'h000);
		axr(ADDR_STATUS, rd, RESP_OKAY);
		chk(rd[4:0], POS_FIRST);
		chk(rd[ST_LOCK_BIT], 1'b1);
		uv <= 1'b1;
		cyc(3);
		axr(ADDR_STATUS, rd, RESP_OKAY);
		chk(rd[ST_LOCK_BIT], 1'b0);
		chk(aux, 1'b1);
		wait_pos(POS_START);
		chk(ord.size(), 11);
		for (int k = 0; k < 11; k++) chk(ord[k], k);
		chk(multi, 0);
		axr(ADDR_UNITS, rd, RESP_OKAY);
		chk(rd[6:0], 7'h7F);
		wait_por;
		chk(por_n, 1);
		chk(por_len, POR_CYC);
	endtask
	task automatic t_off;
		off_b <= 1'b1;
		cyc(1);
		off_b <= 1'b0;
		cyc(3);
		chk(shold, 1'b0);
		chk(ctr, 1'b1);
		wait_ctr(1'b0);
		chk(sdown, 1'b1);
		cyc(2);
		chk(chold, 1'b0);
		uv <= 1'b0;
		cyc(2 * LK);
		axr(ADDR_STATUS, rd, RESP_OKAY);
		chk(rd[ST_LOCK_BIT], 1'b1);
		chk(rd[4:0], POS_START);
	endtask
	task automatic t_orig_cpu;
		axw(ADDR_CTRL, 32'h0);
		axw(ADDR_CMD, 32'h1);
		wait_ctr(1'b1);
		uv <= 1'b1;
		wait_pos(POS_ORIG_END);
		wait_por;
		chk(por_n, 3);
		chk(aux, 1'b0);
		rdy <= 1'b0;
		cyc(4);
		chk(ctr, 1'b0);
		chk(shold, 1'b1);
		uv <= 1'b0;
		axw(ADDR_CMD, 32'h4);
		cyc(2 * LK);
		chk(ctr, 1'b0);
		rdy <= 1'b1;
		cyc(2);
		cpu_b <= 1'b1;
		cyc(4);
		cpu_b <= 1'b0;
		chk(ctr, 1'b0);
		cyc(2 * LK);
		axw(ADDR_CMD, 32'h4);
		wait_ctr(1'b1);
		chk(ctr, 1'b1);
		cyc(PG + 5);
		chk(ctr, 1'b0);
		cyc(2 * LK);
		cpu_b <= 1'b1;
		cyc(1);
		cpu_b <= 1'b0;
		wait_ctr(1'b1);
		uv <= 1'b1;
		cyc(PG + 5);
		chk(ctr, 1'b1);
		flt <= 1'b1;
		cyc(4);
		chk(ctr, 1'b0);
		chk(prim, 1'b1);
		flt <= 1'b0;
		emergency_off <= 1'b1;
		cyc(4);
		chk(prim, 1'b0);
		chk(shold, 1'b0);
	endtask
	task automatic results;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		cyc(3);
		sys_rst_in <= 1'b0;
		cyc(2);
		t_regs;
		t_on_conv;
		t_off;
		t_orig_cpu;
		results;
	end
	initial begin
		#400000;
		failures++;
		results;
	end
endmodule // system_power_sequencer_tb_top
`default_nettype wire
